// ### rtl/csd_pkg.sv
// Constants for the current set point and dither configuration block
package csd_pkg;
	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int FRAME_W       = 32;
	localparam int DIR_BIT       = 31;
	localparam int SEL_HI        = 30;
	localparam int SEL_LO        = 26;
	localparam int CH_HI         = 25;
	localparam int CH_LO         = 24;
	localparam int EN_LOW_BIT    = 23;
	localparam int ON_BIT        = 22;
	localparam int STEP_HI       = 21;
	localparam int STEP_LO       = 12;
	localparam int DITHER_EN_BIT = 11;
	localparam int SP_HI         = 10;
	localparam int SP_LO         = 0;
	localparam int CNT_HI        = 5;
	localparam int CNT_LO        = 0;

	// ------------------------------------------------------------
	// Selector codes, widths and reset values
	// ------------------------------------------------------------
	localparam logic [4:0]  SEL_SETPOINT = 5'h03;
	localparam logic [4:0]  SEL_PERIOD   = 5'h04;
	localparam int          NUM_CH       = 4;
	localparam int          CH_W         = 2;
	localparam int          STEP_W       = 10;
	localparam int          SP_W         = 11;
	localparam int          CNT_W        = 6;
	localparam int          FRAC_W       = 4;
	localparam int          CMD_W        = 15;
	localparam int          AMP_W        = 18;
	localparam logic [CMD_W-1:0] CMD_MAX = 15'h7FFF;
	localparam logic [FRAME_W-1:0] SETPOINT_RST = 32'h00000000;
	localparam logic [FRAME_W-1:0] PERIOD_RST   = 32'h00000000;

	// ------------------------------------------------------------
	// Dither quarter phases
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		Q_RISE0 = 2'b00,
		Q_FALL0 = 2'b01,
		Q_FALL1 = 2'b10,
		Q_RISE1 = 2'b11
	} quarter_t;
endpackage

// ### rtl/dither_gen.sv
// Triangular dither generator and commanded current for one channel
`timescale 1ns/10ps
module dither_gen
	import csd_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Pacing
	input  wire logic              pwm_tick,
	// Settings
	input  wire logic              dither_en,
	input  wire logic [STEP_W-1:0] step_size,
	input  wire logic [CNT_W-1:0]  step_count,
	input  wire logic [SP_W-1:0]   setpoint,
	// Result, units of 2^-15 of full scale
	output logic      [CMD_W-1:0]  current_cmd
);
	logic signed [AMP_W-1:0] acc_ff;
	logic        [CNT_W-1:0] cnt_ff;
	quarter_t                quarter_ff;
	logic                    active;
	logic signed [AMP_W-1:0] step_ext;
	logic signed [AMP_W:0]   sum;
	logic        [CMD_W-1:0] current_cmd_ff;

	assign active   = dither_en && (step_count != '0);
	assign step_ext = $signed({{(AMP_W-STEP_W){1'b0}}, step_size});

	// ------------------------------------------------------------
	// Waveform: up one quarter, down two, up one, one step a tick
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset || !active)
		begin
			acc_ff     <= '0;
			cnt_ff     <= '0;
			quarter_ff <= Q_RISE0;
		end
		else if (pwm_tick)
		begin
			unique case (quarter_ff)
				Q_RISE0, Q_RISE1: acc_ff <= acc_ff + step_ext;
				Q_FALL0, Q_FALL1: acc_ff <= acc_ff - step_ext;
			endcase
			// Compare with >= so a shorter count written mid-cycle recovers
			if (cnt_ff >= step_count - 6'h01)
			begin
				cnt_ff     <= '0;
				quarter_ff <= quarter_t'(quarter_ff + 2'h1);
			end
			else
				cnt_ff <= cnt_ff + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// Set point scaled to step units plus dither, clamped
	// ------------------------------------------------------------
	assign sum = $signed({4'h0, setpoint, {FRAC_W{1'b0}}})
		+ $signed({acc_ff[AMP_W-1], acc_ff});

	always_ff @(posedge clk)
	begin
		if (reset)
			current_cmd_ff <= '0;
		else if (sum < 0)
			current_cmd_ff <= '0;
		else if (sum > $signed({4'h0, CMD_MAX}))
			current_cmd_ff <= CMD_MAX;
		else
			current_cmd_ff <= sum[CMD_W-1:0];
	end

	assign current_cmd = current_cmd_ff;

	a_dither_step_size: assert property (
		@(posedge clk) disable iff (reset)
		(active && pwm_tick) |=> (!active
			|| (acc_ff - $past(acc_ff) == $past(step_ext))
			|| ($past(acc_ff) - acc_ff == $past(step_ext))))
		else $error("dither moved by other than one step");

	a_dither_off_zero: assert property (
		@(posedge clk) disable iff (reset)
		!dither_en |=> acc_ff == '0)
		else $error("dither not cleared while disabled");

	a_plain_setpoint: assert property (
		@(posedge clk) disable iff (reset)
		!dither_en [*2] |=> current_cmd == {$past(setpoint), 4'h0})
		else $error("command differs from set point without dither");

	a_quarter_length: assert property (
		@(posedge clk) disable iff (reset)
		(active && pwm_tick && cnt_ff == step_count - 6'h01)
		|=> (!active || (cnt_ff == '0 && quarter_ff != $past(quarter_ff))))
		else $error("quarter did not end after step count ticks");
endmodule

// ### rtl/current_setpoint_dither_config.sv
// Per-channel set point and dither settings written by serial frames
//
// Functional notes
// - Frame bit 31 selects a read (0) or a write (1) of the settings.
// - Selector 0 0011 at bits 30:26 picks set point; 25:24 pick channel.
// - Selector 0 0100 picks the dither period, same field positions.
// - Bit 23 set keeps regulating with enable low; clear switches off.
// - Bit 22 commands the channel on (1) or off (0) in on/off use.
// - Bits 21:12 hold the dither step, its LSB 1/16 of a set point LSB.
// - Bit 11 enables the dither added to the commanded current.
// - Bits 10:0 hold the unsigned average current set point.
// - Period bits 5:0 give the PWM periods per dither quarter.
// - Dither moves one step per PWM period, 2*step*count peak to peak.
// - All settings of every channel are zero after reset.
`timescale 1ns/10ps
module current_setpoint_dither_config
	import csd_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// Received frame, one-cycle strobe
	input  wire logic                          frame_valid,
	input  wire logic [FRAME_W-1:0]            frame_data,
	// Response frame
	output logic                               resp_valid,
	output logic      [FRAME_W-1:0]            resp_data,
	// Pins and pacing
	input  wire logic                          enable_pin,
	input  wire logic                          pwm_tick,
	// Channel outputs
	output logic      [NUM_CH-1:0]             channel_on,
	output logic      [NUM_CH-1:0]             channel_regulate,
	output logic      [NUM_CH-1:0][CMD_W-1:0]  current_cmd
);
	logic              en_low_keep_ff [NUM_CH];
	logic              on_cmd_ff      [NUM_CH];
	logic              dither_en_ff   [NUM_CH];
	logic [STEP_W-1:0] step_ff        [NUM_CH];
	logic [SP_W-1:0]   setpoint_ff    [NUM_CH];
	logic [CNT_W-1:0]  count_ff       [NUM_CH];
	logic [NUM_CH-1:0] channel_on_ff;
	logic [NUM_CH-1:0] regulate_ff;
	logic              resp_valid_ff;
	logic [FRAME_W-1:0] resp_data_ff;

	logic              is_write;
	logic [4:0]        message_selector;
	logic              channel_select_high;
	logic              channel_select_low;
	logic [CH_W-1:0]   ch;
	logic              hit_setpoint;
	logic              hit_period;

	// ------------------------------------------------------------
	// Frame decode
	// ------------------------------------------------------------
	assign is_write            = frame_data[DIR_BIT];
	assign message_selector    = frame_data[SEL_HI:SEL_LO];
	assign channel_select_high = frame_data[CH_HI];
	assign channel_select_low  = frame_data[CH_LO];
	assign ch = {channel_select_high, channel_select_low};
	assign hit_setpoint = frame_valid
		&& message_selector == SEL_SETPOINT;
	assign hit_period   = frame_valid
		&& message_selector == SEL_PERIOD;

	// ------------------------------------------------------------
	// Per-channel settings and outputs
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		localparam logic [CH_W-1:0] CH_ID = CH_W'(i);

		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				en_low_keep_ff[i] <= SETPOINT_RST[EN_LOW_BIT];
				on_cmd_ff[i]      <= SETPOINT_RST[ON_BIT];
				step_ff[i]        <= SETPOINT_RST[STEP_HI:STEP_LO];
				dither_en_ff[i]   <= SETPOINT_RST[DITHER_EN_BIT];
				setpoint_ff[i]    <= SETPOINT_RST[SP_HI:SP_LO];
			end
			else if (hit_setpoint && is_write && ch == CH_ID)
			begin
				en_low_keep_ff[i] <= frame_data[EN_LOW_BIT];
				on_cmd_ff[i]      <= frame_data[ON_BIT];
				step_ff[i]        <= frame_data[STEP_HI:STEP_LO];
				dither_en_ff[i]   <= frame_data[DITHER_EN_BIT];
				setpoint_ff[i]    <= frame_data[SP_HI:SP_LO];
			end
		end

		// Unused bits of the period frame are dropped here
		always_ff @(posedge clk)
		begin
			if (reset)
				count_ff[i] <= PERIOD_RST[CNT_HI:CNT_LO];
			else if (hit_period && is_write && ch == CH_ID)
				count_ff[i] <= frame_data[CNT_HI:CNT_LO];
		end

		// Enable pin low: off unless told to keep regulating
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				regulate_ff[i]   <= 1'b0;
				channel_on_ff[i] <= 1'b0;
			end
			else
			begin
				regulate_ff[i]   <= enable_pin || en_low_keep_ff[i];
				channel_on_ff[i] <= on_cmd_ff[i]
					&& (enable_pin || en_low_keep_ff[i]);
			end
		end

		dither_gen u_dither_gen (
			.clk         (clk),
			.reset       (reset),
			.pwm_tick    (pwm_tick),
			.dither_en   (dither_en_ff[i]),
			.step_size   (step_ff[i]),
			.step_count  (count_ff[i]),
			.setpoint    (setpoint_ff[i]),
			.current_cmd (current_cmd[i])
		);
	end

	assign channel_on       = channel_on_ff;
	assign channel_regulate = regulate_ff;

	// ------------------------------------------------------------
	// Response, one cycle after the frame, showing post-write state
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			resp_valid_ff <= 1'b0;
			resp_data_ff  <= '0;
		end
		else if (hit_setpoint)
		begin
			resp_valid_ff <= 1'b1;
			resp_data_ff  <= '0;
			resp_data_ff[SEL_HI:SEL_LO] <= SEL_SETPOINT;
			resp_data_ff[CH_HI:CH_LO]   <= ch;
			if (is_write)
			begin
				resp_data_ff[EN_LOW_BIT:SP_LO] <= frame_data[EN_LOW_BIT:SP_LO];
			end
			else
			begin
				resp_data_ff[EN_LOW_BIT]      <= en_low_keep_ff[ch];
				resp_data_ff[ON_BIT]          <= on_cmd_ff[ch];
				resp_data_ff[STEP_HI:STEP_LO] <= step_ff[ch];
				resp_data_ff[DITHER_EN_BIT]   <= dither_en_ff[ch];
				resp_data_ff[SP_HI:SP_LO]     <= setpoint_ff[ch];
			end
		end
		else if (hit_period)
		begin
			resp_valid_ff <= 1'b1;
			resp_data_ff  <= '0;
			resp_data_ff[SEL_HI:SEL_LO] <= SEL_PERIOD;
			resp_data_ff[CH_HI:CH_LO]   <= ch;
			resp_data_ff[CNT_HI:CNT_LO] <= is_write
				? frame_data[CNT_HI:CNT_LO] : count_ff[ch];
		end
		else
		begin
			resp_valid_ff <= 1'b0;
			resp_data_ff  <= '0;
		end
	end

	assign resp_valid = resp_valid_ff;
	assign resp_data  = resp_data_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_write_setpoint: assert property (
		@(posedge clk) disable iff (reset)
		(hit_setpoint && is_write) |=>
		setpoint_ff[$past(ch)] == $past(frame_data[SP_HI:SP_LO])
		&& step_ff[$past(ch)] == $past(frame_data[STEP_HI:STEP_LO]))
		else $error("set point write not stored");

	a_read_keeps: assert property (
		@(posedge clk) disable iff (reset)
		(hit_setpoint && !is_write && ch == 2'h0) |=>
		$stable(setpoint_ff[0]) && $stable(step_ff[0]))
		else $error("read changed stored settings");

	a_write_period: assert property (
		@(posedge clk) disable iff (reset)
		(hit_period && is_write) |=>
		count_ff[$past(ch)] == $past(frame_data[CNT_HI:CNT_LO]))
		else $error("period write not stored");

	a_period_answer: assert property (
		@(posedge clk) disable iff (reset)
		hit_period |=> resp_valid
		&& resp_data[FRAME_W-1:CNT_HI+1]
		== {1'b0, SEL_PERIOD, $past(ch), 18'h00000})
		else $error("period answer malformed");

	a_setpoint_answer: assert property (
		@(posedge clk) disable iff (reset)
		(hit_setpoint && !is_write) |=> resp_valid
		&& resp_data[SEL_HI:CH_LO] == {SEL_SETPOINT, $past(ch)}
		&& resp_data[SP_HI:SP_LO] == $past(setpoint_ff[ch]))
		else $error("set point answer malformed");

	a_enable_low_off: assert property (
		@(posedge clk) disable iff (reset)
		(!enable_pin && !en_low_keep_ff[0]) |=> !channel_on[0]
		&& !channel_regulate[0])
		else $error("channel on while enable low");

	a_on_command: assert property (
		@(posedge clk) disable iff (reset)
		(enable_pin && $stable(on_cmd_ff[1]))
		|=> channel_on[1] == $past(on_cmd_ff[1]))
		else $error("channel output differs from command");

	a_reset_zero: assert property (
		@(posedge clk)
		reset |=> setpoint_ff[3] == '0 && count_ff[3] == '0
		&& !dither_en_ff[3] && !on_cmd_ff[3] && !resp_valid)
		else $error("settings not cleared by reset");
endmodule

// ### bench/spi_host_model.sv
// Behavioural serial host that hands whole frames to the block
`timescale 1ns/10ps
module spi_host_model
	import csd_pkg::*;
(
	// Clock
	input  wire logic               clk,
	// Frame strobe and word
	output logic                    frame_valid,
	output logic      [FRAME_W-1:0] frame_data
);
	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	initial
	begin
		frame_valid = 1'b0;
		frame_data  = 32'h00000000;
	end

	// One strobe per whole frame: direction, selector, channel
	task automatic send(input logic [FRAME_W-1:0] f);
		@(posedge clk);
		frame_valid <= 1'b1;
		frame_data  <= f;
		@(posedge clk);
		frame_valid <= 1'b0;
		// Stale word inverted, so nothing latches it by luck
		frame_data  <= ~f;
	endtask
endmodule

// ### bench/current_setpoint_dither_config_test.sv
// Self-checking bench for the set point and dither settings block
`timescale 1ns/10ps
module current_setpoint_dither_config_test;
	import csd_pkg::*;
	logic                         clk;
	logic                         reset;
	logic                         frame_valid;
	logic [FRAME_W-1:0]           frame_data;
	logic                         resp_valid;
	logic [FRAME_W-1:0]           resp_data;
	logic                         enable_pin;
	logic                         pwm_tick;
	logic [NUM_CH-1:0]            channel_on;
	logic [NUM_CH-1:0]            channel_regulate;
	logic [NUM_CH-1:0][CMD_W-1:0] current_cmd;
	int                           bad_count;
	int                           n_checks;
	int                           seed;
	logic [31:0]                  exp_q[$];
	logic [23:0]                  body[NUM_CH];
	logic [31:0]                  f;
	logic [31:0]                  d;
	logic [3:0]                   reg_e;
	logic [3:0]                   on_e;
	int                           offs[8] = '{5, 10, 5, 0, -5, -10, -5, 0};

	spi_host_model u_host (.clk(clk), .frame_valid(frame_valid),
		.frame_data(frame_data));

	current_setpoint_dither_config u_current_setpoint_dither_config (
		.clk(clk), .reset(reset), .frame_valid(frame_valid),
		.frame_data(frame_data), .resp_valid(resp_valid),
		.resp_data(resp_data), .enable_pin(enable_pin),
		.pwm_tick(pwm_tick), .channel_on(channel_on),
		.channel_regulate(channel_regulate), .current_cmd(current_cmd));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks=%0d errors=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [31:0] fr(input logic w, input logic [4:0] s,
		input logic [1:0] c, input logic [23:0] b);
		return {w, s, c, b};
	endfunction

	// Note the answer first, so the watcher always has it queued
	task automatic xfer(input logic [31:0] fw, input logic [31:0] e);
		exp_q.push_back(e);
		u_host.send(fw);
		repeat (2) @(posedge clk);
	endtask

	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic tick;
		@(posedge clk);
		pwm_tick <= 1'b1;
		@(posedge clk);
		pwm_tick <= 1'b0;
		settle();
	endtask

	// Answers are compared in arrival order; a stray answer is an error
	always @(negedge clk)
		if (resp_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(resp_data, 32'hFFFFFFFF);
			else
				check(resp_data, exp_q.pop_front());
		end

	initial
	begin
		#(25 * 6000);
		bad_count++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		seed = 41510;
		reset = 1'b1;
		enable_pin = 1'b0;
		pwm_tick = 1'b0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			f = fr(1'b0, SEL_SETPOINT, 2'(c), 24'h0);
			xfer(f, f);
			f = fr(1'b0, SEL_PERIOD, 2'(c), 24'h0);
			xfer(f, f);
		end
		// Bits 23:22 forced per channel so every keep/on pairing is seen
		for (int c = 0; c < NUM_CH; c++)
		begin
			body[c] = 24'($random(seed));
			body[c][23:22] = 2'(c);
			f = fr(1'b1, SEL_SETPOINT, 2'(c), body[c]);
			xfer(f, {1'b0, f[30:0]});
		end
		settle();
		for (int c = 0; c < NUM_CH; c++)
		begin
			d = {17'h0, body[c][10:0], 4'h0};
			check({17'h0, current_cmd[c]}, d);
		end
		for (int p = 0; p < 2; p++)
		begin
			@(posedge clk);
			enable_pin <= p[0];
			settle();
			for (int c = 0; c < NUM_CH; c++)
			begin
				reg_e[c] = p[0] | body[c][23];
				on_e[c] = body[c][22] & reg_e[c];
			end
			check({28'h0, channel_regulate}, {28'h0, reg_e});
			check({28'h0, channel_on}, {28'h0, on_e});
		end
		// Unknown selector must neither answer nor store
		u_host.send(fr(1'b1, 5'h05, 2'd0, 24'hFFFFFF));
		f = fr(1'b0, SEL_SETPOINT, 2'd0, body[0]);
		xfer(fr(1'b0, SEL_SETPOINT, 2'd0, 24'h0), f);
		for (int c = 0; c < NUM_CH; c++)
		begin
			d = $random(seed);
			f = fr(1'b0, SEL_PERIOD, 2'(c), {18'h0, d[5:0]});
			xfer(fr(1'b1, SEL_PERIOD, 2'(c), d[23:0]), f);
			xfer(fr(1'b0, SEL_PERIOD, 2'(c), ~d[23:0]), f);
		end
		// Triangle on channel 1: step 5, two ticks per quarter
		f = fr(1'b1, SEL_PERIOD, 2'd1, 24'h2);
		xfer(f, {1'b0, f[30:0]});
		f = fr(1'b1, SEL_SETPOINT, 2'd1, 24'h005900);
		xfer(f, {1'b0, f[30:0]});
		settle();
		check({17'h0, current_cmd[1]}, 32'h00001000);
		for (int k = 0; k < 8; k++)
		begin
			tick();
			check({17'h0, current_cmd[1]}, 32'(4096 + offs[k]));
		end
		// Dither off while an offset of one step is left behind
		tick();
		f = fr(1'b1, SEL_SETPOINT, 2'd1, 24'h005100);
		xfer(f, {1'b0, f[30:0]});
		settle();
		check({17'h0, current_cmd[1]}, 32'h00001000);
		// Mid-run reset must clear written settings, channel_on and current_cmd
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		settle();
		check({28'h0, channel_on}, 32'h00000000);
		check({28'h0, channel_regulate}, 32'h0000000F);
		check({17'h0, current_cmd[1]}, 32'h00000000);
		f = fr(1'b0, SEL_SETPOINT, 2'd1, 24'h0);
		xfer(f, f);
		f = fr(1'b0, SEL_PERIOD, 2'd1, 24'h0);
		xfer(f, f);
		check(32'(exp_q.size()), 32'h00000000);
		complete_run();
	end
endmodule
